// *** common/sbt_pkg.sv ***
// Purpose: constants for the sequential break and trace trigger block
// Assumes: one core clock, plain register port with one-cycle read latency
// Notes: register map and field layouts below
// Functional notes
// R1 - Channel match counts only after prerequisite channel matched
// R2 - Prerequisite may be the shared match flag
// R3 - Prerequisite channel never breaks by itself
// R4 - Match action sets, clears or keeps flag
// R5 - Any program break clears the match flag
// R6 - System bus channels sequence independently, same scheme
// R7 - Branch trace records source, destination, type, master
// R8 - Range trace captures only addresses inside window
// R9 - Range trace selects read, write or both; ASID
// R10 - No ASID condition means ASID is don't-care
// R11 - Range capture needs acquire-trace action enabled
// R12 - Break when non-prerequisite channel matches with prerequisites met
package sbt_pkg;
  localparam int NCPU = 8;
  localparam int NSYS = 2;
  localparam int NCH = NCPU + NSYS;
  localparam int CHW = 4;
  localparam int AW = 6;
  // Prerequisite select encoding: 0 none, 1..N channel index+1 within the group, 15 match flag
  localparam logic [3:0] PRE_NONE = 4'h0;
  localparam logic [3:0] PRE_FLAG = 4'hf;
  // Flag action encoding
  localparam logic [1:0] ACT_KEEP = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  // Register offsets
  localparam logic [AW-1:0] REG_CH_CFG0 = 6'h00;
  localparam logic [AW-1:0] REG_STATUS = 6'h10;
  localparam logic [AW-1:0] REG_RANGE_START = 6'h11;
  localparam logic [AW-1:0] REG_RANGE_END = 6'h12;
  localparam logic [AW-1:0] REG_RANGE_CTRL = 6'h13;
  localparam logic [AW-1:0] REG_BR_SRC = 6'h14;
  localparam logic [AW-1:0] REG_BR_DST = 6'h15;
  localparam logic [AW-1:0] REG_BR_INFO = 6'h16;
  localparam logic [AW-1:0] REG_BR_CTRL = 6'h17;
  localparam logic [AW-1:0] REG_TRC_BASE = 6'h20;
  // Channel config fields
  localparam int CF_PRE_LSB = 0;
  localparam int CF_ACT_LSB = 4;
  localparam int CF_EN_BIT = 6;
  // Range control fields
  localparam int RC_RD_BIT = 0;
  localparam int RC_WR_BIT = 1;
  localparam int RC_ASEN_BIT = 2;
  localparam int RC_ACQ_BIT = 3;
  localparam int RC_ASID_LSB = 8;
  localparam int ASIDW = 8;
  // Trace memory
  localparam int TRC_DEPTH = 8;
  localparam int TRC_AW = 3;
  localparam int TRC_W = 32;
endpackage

// *** core/sbt_trace_mem.sv ***
// Purpose: small trace capture memory with registered read data
// Assumes: one write and one read port on the core clock
// Notes: circular write pointer kept by the caller
`timescale 1ns/1ps
module sbt_trace_mem
  import sbt_pkg::*;
(
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wrEn,
  input wire logic [TRC_AW-1:0] wrAddr,
  input wire logic [TRC_W-1:0] wrData,
  // Read side
  input wire logic [TRC_AW-1:0] rdAddr,
  output logic [TRC_W-1:0] rdData
);
  logic [TRC_W-1:0] mem [TRC_DEPTH];

  // Storage and registered read
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // sbt_trace_mem

// *** core/sbt_seq_group.sv ***
// Purpose: prerequisite and match-flag sequencing for one channel group
// Assumes: raw channel matches are one-cycle pulses from the comparators
// Notes: used once for core channels and once for system bus channels
`timescale 1ns/1ps
module sbt_seq_group
  import sbt_pkg::*;
#(
  parameter int N = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration
  input wire logic [N*CHW-1:0] preSel,
  input wire logic [N*2-1:0] flagAct,
  input wire logic [N-1:0] chEn,
  // Events
  input wire logic [N-1:0] rawMatch,
  input wire logic breakIn,
  // Results
  output logic breakOut,
  output logic [N-1:0] armed,
  output logic matchFlag
);
  logic [N-1:0] armed_r, armed_nxt;
  logic flag_r, flag_nxt;
  logic [N-1:0] qualMatch, isPre;

  // Qualify each channel by its prerequisite
  always_comb begin
    isPre = '0;
    breakOut = 1'b0;
    for (int i = 0; i < N; i++) begin
      logic [CHW-1:0] s;
      s = preSel[i*CHW +: CHW];
      qualMatch[i] = rawMatch[i] & chEn[i];
      if (s == PRE_FLAG) begin
        qualMatch[i] = qualMatch[i] & flag_r; // R2
      end else if (s != PRE_NONE && int'(s) <= N) begin
        qualMatch[i] = qualMatch[i] & armed_r[int'(s) - 1]; // R1
        isPre[int'(s) - 1] = 1'b1;
      end
    end
    for (int i = 0; i < N; i++) begin
      if (qualMatch[i] && !isPre[i]) begin
        breakOut = 1'b1; // R3 R12
      end
    end
  end

  // Arm state and flag actions
  always_comb begin
    armed_nxt = armed_r | qualMatch;
    flag_nxt = flag_r;
    for (int i = 0; i < N; i++) begin
      if (qualMatch[i] && flagAct[i*2 +: 2] == ACT_SET) begin
        flag_nxt = 1'b1; // R4
      end else if (qualMatch[i] && flagAct[i*2 +: 2] == ACT_CLR) begin
        flag_nxt = 1'b0; // R4
      end
    end
    if (breakIn) begin
      flag_nxt = 1'b0; // R5
      armed_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      armed_r <= '0;
      flag_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign armed = armed_r;
  assign matchFlag = flag_r;
endmodule // sbt_seq_group

// *** core/sbt_trigger.sv ***
// Purpose: sequential break and trace trigger top
// Assumes: bus signals from the core on the same clock, used here without an input register
// Notes: raw matches come from external comparators, one bit per channel
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module sbt_trigger
  import sbt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [AW-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Channel comparator matches
  input wire logic [NCPU-1:0] cpuRawMatch,
  input wire logic [NSYS-1:0] sysRawMatch,
  // Branch events
  input wire logic branchValid,
  input wire logic [31:0] branchSrc,
  input wire logic [31:0] branchDst,
  input wire logic [3:0] branchType,
  input wire logic [1:0] branchMaster,
  // Data bus
  input wire logic busValid,
  input wire logic busWrite,
  input wire logic [31:0] busAddr,
  input wire logic [ASIDW-1:0] busAsid,
  // Results
  output logic programBreak,
  output logic cpuMatchFlag,
  output logic sysMatchFlag,
  output logic rangeHit
);
  logic [6:0] chCfg_r [NCH];
  logic [6:0] chCfg_nxt [NCH];
  logic [31:0] rStart_r, rStart_nxt, rEnd_r, rEnd_nxt;
  logic [15:0] rCtrl_r, rCtrl_nxt;
  logic brAcq_r, brAcq_nxt;
  logic [31:0] brSrc_r, brSrc_nxt, brDst_r, brDst_nxt;
  logic [5:0] brInfo_r, brInfo_nxt;
  logic [TRC_AW-1:0] wp_r, wp_nxt;
  logic [3:0] trcCnt_r, trcCnt_nxt;
  logic brk_r, brk_nxt, hit_r, hit_nxt;
  logic [AW-1:0] rdAddr_r;
  logic rdTrc_r;
  logic [31:0] rdMux_r, rdMux_nxt;
  logic [NCPU*CHW-1:0] cpuPre;
  logic [NCPU*2-1:0] cpuAct;
  logic [NCPU-1:0] cpuEn, cpuArmed;
  logic [NSYS*CHW-1:0] sysPre;
  logic [NSYS*2-1:0] sysAct;
  logic [NSYS-1:0] sysEn, sysArmed;
  logic cpuBrk, sysBrk, anyBreak;
  logic inWin, dirOk, asidOk, rangeMatch, capture;
  logic [TRC_W-1:0] trcRdata;

  // Unpack channel configuration per group
  for (genvar g = 0; g < NCH; g++) begin : gCfg
    if (g < NCPU) begin : gCpu
      assign cpuPre[g*CHW +: CHW] = chCfg_r[g][CF_PRE_LSB +: CHW];
      assign cpuAct[g*2 +: 2] = chCfg_r[g][CF_ACT_LSB +: 2];
      assign cpuEn[g] = chCfg_r[g][CF_EN_BIT];
    end else begin : gSys
      assign sysPre[(g-NCPU)*CHW +: CHW] = chCfg_r[g][CF_PRE_LSB +: CHW];
      assign sysAct[(g-NCPU)*2 +: 2] = chCfg_r[g][CF_ACT_LSB +: 2];
      assign sysEn[g-NCPU] = chCfg_r[g][CF_EN_BIT];
    end
  end

  assign anyBreak = cpuBrk | sysBrk;

  // Core channel sequencer
  sbt_seq_group #(.N(NCPU)) uCpu (
    .clk(clk),
    .resetn(resetn),
    .preSel(cpuPre),
    .flagAct(cpuAct),
    .chEn(cpuEn),
    .rawMatch(cpuRawMatch),
    .breakIn(anyBreak),
    .breakOut(cpuBrk),
    .armed(cpuArmed),
    .matchFlag(cpuMatchFlag)
  );

  // System bus sequencer, own flag and arm state
  sbt_seq_group #(.N(NSYS)) uSys ( // R6
    .clk(clk),
    .resetn(resetn),
    .preSel(sysPre),
    .flagAct(sysAct),
    .chEn(sysEn),
    .rawMatch(sysRawMatch),
    .breakIn(anyBreak),
    .breakOut(sysBrk),
    .armed(sysArmed),
    .matchFlag(sysMatchFlag)
  );

  // Range window qualification
  always_comb begin
    inWin = (busAddr >= rStart_r) && (busAddr <= rEnd_r); // R8
    dirOk = busWrite ? rCtrl_r[RC_WR_BIT] : rCtrl_r[RC_RD_BIT]; // R9
    asidOk = !rCtrl_r[RC_ASEN_BIT] ||
      (busAsid == rCtrl_r[RC_ASID_LSB +: ASIDW]); // R10
    rangeMatch = busValid && inWin && dirOk && asidOk;
    capture = rangeMatch && rCtrl_r[RC_ACQ_BIT]; // R11
  end

  // Register writes, branch capture and trace pointer
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chCfg_nxt[i] = chCfg_r[i];
      if (regWr && regAddr == REG_CH_CFG0 + AW'(i)) begin
        chCfg_nxt[i] = regWdata[6:0];
      end
    end
    rStart_nxt = rStart_r;
    rEnd_nxt = rEnd_r;
    rCtrl_nxt = rCtrl_r;
    brAcq_nxt = brAcq_r;
    if (regWr && regAddr == REG_RANGE_START) begin
      rStart_nxt = regWdata;
    end
    if (regWr && regAddr == REG_RANGE_END) begin
      rEnd_nxt = regWdata;
    end
    if (regWr && regAddr == REG_RANGE_CTRL) begin
      rCtrl_nxt = regWdata[15:0];
    end
    if (regWr && regAddr == REG_BR_CTRL) begin
      brAcq_nxt = regWdata[0];
    end
    brSrc_nxt = brSrc_r;
    brDst_nxt = brDst_r;
    brInfo_nxt = brInfo_r;
    if (branchValid && brAcq_r) begin
      brSrc_nxt = branchSrc; // R7
      brDst_nxt = branchDst; // R7
      brInfo_nxt = {branchMaster, branchType}; // R7
    end
    wp_nxt = capture ? wp_r + TRC_AW'(1) : wp_r;
    trcCnt_nxt = trcCnt_r;
    if (capture && trcCnt_r != 4'(TRC_DEPTH)) begin
      trcCnt_nxt = trcCnt_r + 4'h1;
    end
    brk_nxt = anyBreak;
    hit_nxt = rangeMatch;
  end

  // Read data selection
  always_comb begin
    rdMux_nxt = 32'h0;
    if (regRd) begin
      if (regAddr < REG_CH_CFG0 + AW'(NCH)) begin
        rdMux_nxt = {25'h0, chCfg_r[regAddr[3:0]]};
      end else begin
        unique case (regAddr)
          REG_STATUS: rdMux_nxt = {16'h0, trcCnt_r, 2'h0, sysArmed, cpuArmed};
          REG_RANGE_START: rdMux_nxt = rStart_r;
          REG_RANGE_END: rdMux_nxt = rEnd_r;
          REG_RANGE_CTRL: rdMux_nxt = {16'h0, rCtrl_r};
          REG_BR_SRC: rdMux_nxt = brSrc_r;
          REG_BR_DST: rdMux_nxt = brDst_r;
          REG_BR_INFO: rdMux_nxt = {26'h0, brInfo_r};
          REG_BR_CTRL: rdMux_nxt = {31'h0, brAcq_r};
          default: rdMux_nxt = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        chCfg_r[i] <= 7'h0;
      end
      rStart_r <= 32'h0;
      rEnd_r <= 32'h0;
      rCtrl_r <= 16'h0;
      brAcq_r <= 1'b0;
      brSrc_r <= 32'h0;
      brDst_r <= 32'h0;
      brInfo_r <= 6'h0;
      wp_r <= '0;
      trcCnt_r <= 4'h0;
      brk_r <= 1'b0;
      hit_r <= 1'b0;
      rdAddr_r <= '0;
      rdTrc_r <= 1'b0;
      rdMux_r <= 32'h0;
    end else begin
      chCfg_r <= chCfg_nxt;
      rStart_r <= rStart_nxt;
      rEnd_r <= rEnd_nxt;
      rCtrl_r <= rCtrl_nxt;
      brAcq_r <= brAcq_nxt;
      brSrc_r <= brSrc_nxt;
      brDst_r <= brDst_nxt;
      brInfo_r <= brInfo_nxt;
      wp_r <= wp_nxt;
      trcCnt_r <= trcCnt_nxt;
      brk_r <= brk_nxt;
      hit_r <= hit_nxt;
      rdAddr_r <= regAddr;
      rdTrc_r <= regRd && regAddr >= REG_TRC_BASE &&
        regAddr < REG_TRC_BASE + AW'(TRC_DEPTH);
      rdMux_r <= rdMux_nxt;
    end
  end

  // Range trace storage
  sbt_trace_mem uMem (
    .clk(clk),
    .wrEn(capture), // R11
    .wrAddr(wp_r),
    .wrData(busAddr),
    .rdAddr(regAddr[TRC_AW-1:0]),
    .rdData(trcRdata)
  );

  assign regRdata = rdTrc_r ? trcRdata : rdMux_r;
  assign programBreak = brk_r; // R12
  assign rangeHit = hit_r;
endmodule // sbt_trigger

// *** tb/sbt_trigger_assertions.sv ***
// Purpose: port-level checks for the trigger block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every sbt_trigger instance
`timescale 1ns/1ps
module sbt_trigger_assertions
  import sbt_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic resetn,
  // Events
  input logic [NCPU-1:0] cpuRawMatch,
  input logic [NSYS-1:0] sysRawMatch,
  input logic busValid,
  // Results
  input logic programBreak,
  input logic cpuMatchFlag,
  input logic sysMatchFlag,
  input logic rangeHit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Outputs tied to their causes one cycle earlier
  chk_brk_cause: assert property (
    programBreak |-> $past(|{cpuRawMatch, sysRawMatch}))
    else $error("break without match");
  chk_brk_clear: assert property (
    programBreak && !(|{cpuRawMatch, sysRawMatch}) |=> !cpuMatchFlag && !sysMatchFlag)
    else $error("flags not cleared after break");
  chk_cflag_rise: assert property (
    $rose(cpuMatchFlag) |-> $past(|cpuRawMatch))
    else $error("core flag set without match");
  // A break from either group clears the flag on the same edge that raises programBreak
  chk_cflag_fall: assert property (
    $fell(cpuMatchFlag) |-> programBreak || $past(|cpuRawMatch))
    else $error("core flag cleared without cause");
  chk_cflag_hold: assert property (
    !(|{cpuRawMatch, sysRawMatch}) |=> $stable(cpuMatchFlag))
    else $error("core flag moved while idle");
  chk_sflag_rise: assert property (
    $rose(sysMatchFlag) |-> $past(|sysRawMatch))
    else $error("system flag set without match");
  chk_sflag_hold: assert property (
    !(|{cpuRawMatch, sysRawMatch}) |=> $stable(sysMatchFlag))
    else $error("system flag moved while idle");
  chk_range_cause: assert property (
    rangeHit |-> $past(busValid))
    else $error("range hit without access");
  // Main scenarios reached
  cov_break: cover property (programBreak);
  cov_flag: cover property ($rose(cpuMatchFlag));
  cov_range: cover property (rangeHit);
endmodule // sbt_trigger_assertions

bind sbt_trigger sbt_trigger_assertions u_chk (.clk(clk), .resetn(resetn),
  .cpuRawMatch(cpuRawMatch), .sysRawMatch(sysRawMatch), .busValid(busValid),
  .programBreak(programBreak), .cpuMatchFlag(cpuMatchFlag),
  .sysMatchFlag(sysMatchFlag), .rangeHit(rangeHit));

// *** tb/sbt_core_model.sv ***
// Purpose: core side model driving comparator hits, branches and accesses
// Assumes: every event lasts one clock
// Notes: released bus and branch data lines show the inverse of their last value; valid and hit lines return to zero
`timescale 1ns/1ps
module sbt_core_model
  import sbt_pkg::*;
(
  // Clock
  input logic clk,
  // Comparator hits
  output logic [NCPU-1:0] cpuRawMatch,
  output logic [NSYS-1:0] sysRawMatch,
  // Branch events
  output logic branchValid,
  output logic [31:0] branchSrc,
  output logic [31:0] branchDst,
  output logic [3:0] branchType,
  output logic [1:0] branchMaster,
  // Data bus
  output logic busValid,
  output logic busWrite,
  output logic [31:0] busAddr,
  output logic [ASIDW-1:0] busAsid
);
  // Idle at time zero
  initial begin
    {cpuRawMatch, sysRawMatch, branchValid, busValid} = '0;
    {branchSrc, branchDst, branchType, branchMaster} = '0;
    {busWrite, busAddr, busAsid} = '0;
  end
  // One cycle of comparator hits
  task automatic hit(input logic [NCPU-1:0] c, input logic [NSYS-1:0] s);
    @(posedge clk);
    {cpuRawMatch, sysRawMatch} <= {c, s};
    @(posedge clk);
    {cpuRawMatch, sysRawMatch} <= '0;
  endtask
  // One data access
  task automatic access(input logic w, input logic [31:0] a, input logic [7:0] id);
    @(posedge clk);
    {busValid, busWrite, busAddr, busAsid} <= {1'b1, w, a, id};
    @(posedge clk);
    {busValid, busWrite, busAddr, busAsid} <= {1'b0, ~w, ~a, ~id};
  endtask
  // One taken branch, info is master then type
  task automatic branch(input logic [31:0] s, input logic [31:0] d, input logic [5:0] f);
    @(posedge clk);
    {branchValid, branchSrc, branchDst, branchMaster, branchType} <= {1'b1, s, d, f};
    @(posedge clk);
    {branchValid, branchSrc, branchDst, branchMaster, branchType} <= {1'b0, ~s, ~d, ~f};
  endtask
endmodule // sbt_core_model

// *** tb/sbt_trigger_tb.sv ***
// Purpose: self-checking bench for the trigger block
// Assumes: 125 MHz clock, reset held 10 cycles
// Notes: fixed seed, corner addresses first in the range loop
`timescale 1ns/1ps
module sbt_trigger_tb
  import sbt_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [AW-1:0] regAddr = '0;
  logic [31:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata, branchSrc, branchDst, busAddr, a, last;
  logic [NCPU-1:0] cpuRawMatch;
  logic [NSYS-1:0] sysRawMatch;
  logic [3:0] branchType, c;
  logic [1:0] branchMaster;
  logic [7:0] busAsid, id;
  logic branchValid, busValid, busWrite, w;
  logic programBreak, cpuMatchFlag, sysMatchFlag, rangeHit;
  logic [31:0] corner [4] = '{32'h140, 32'h17f, 32'h13f, 32'h180};
  int fail_count = 0;
  int compares = 0;
  int nCap = 0;
  always #4 clk = ~clk;
  sbt_trigger DUT (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuRawMatch(cpuRawMatch),
    .sysRawMatch(sysRawMatch), .branchValid(branchValid), .branchSrc(branchSrc),
    .branchDst(branchDst), .branchType(branchType), .branchMaster(branchMaster),
    .busValid(busValid), .busWrite(busWrite), .busAddr(busAddr), .busAsid(busAsid),
    .programBreak(programBreak), .cpuMatchFlag(cpuMatchFlag),
    .sysMatchFlag(sysMatchFlag), .rangeHit(rangeHit));
  sbt_core_model u_core (.clk(clk), .cpuRawMatch(cpuRawMatch),
    .sysRawMatch(sysRawMatch), .branchValid(branchValid), .branchSrc(branchSrc),
    .branchDst(branchDst), .branchType(branchType), .branchMaster(branchMaster),
    .busValid(busValid), .busWrite(busWrite), .busAddr(busAddr), .busAsid(busAsid));
  // Comparisons
  task automatic check_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Register port cycles
  task automatic wr(input logic [AW-1:0] ad, input logic [31:0] d);
    @(posedge clk);
    {regWr, regAddr, regWdata} <= {1'b1, ad, d};
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] ad, input logic [31:0] e);
    @(posedge clk);
    {regRd, regAddr} <= {1'b1, ad};
    @(posedge clk);
    regRd <= 1'b0;
    #1 check_word("regRdata", e, regRdata);
  endtask
  // Hit, then break and flags next cycle; flags checked one cycle after
  task automatic hit(input logic [7:0] cc, input logic [1:0] s, input logic [2:0] e);
    u_core.hit(cc, s);
    #1 check_bit("programBreak", e[2], programBreak);
    @(posedge clk);
    #1 check_bit("cpuMatchFlag", e[1], cpuMatchFlag);
    check_bit("sysMatchFlag", e[0], sysMatchFlag);
  endtask
  function automatic logic [31:0] cfg(logic [3:0] p, logic [1:0] act);
    return {25'h0, 1'b1, act, p};
  endfunction
  function automatic logic exp_hit(logic [3:0] k, logic wv, logic [31:0] av, logic [7:0] iv);
    return av >= 32'h140 && av <= 32'h17f && (wv ? k[1] : k[0]) && (!k[2] || iv == 8'h5a);
  endfunction
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  // Main sequence
  initial begin
    void'($urandom(68156));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(REG_STATUS, 32'h0);
    rd(6'h3f, 32'h0);
    wr(REG_CH_CFG0, cfg(PRE_NONE, ACT_SET));
    wr(REG_CH_CFG0 + 6'h1, cfg(4'h1, ACT_CLR));
    wr(REG_CH_CFG0 + 6'h2, cfg(PRE_FLAG, ACT_KEEP));
    rd(REG_CH_CFG0 + 6'h1, cfg(4'h1, ACT_CLR));
    hit(8'h04, 2'h0, 3'b000);
    hit(8'h02, 2'h0, 3'b000);
    rd(REG_STATUS, 32'h0);
    hit(8'h01, 2'h0, 3'b010);
    rd(REG_STATUS, 32'h1);
    hit(8'h04, 2'h0, 3'b100);
    rd(REG_STATUS, 32'h0);
    hit(8'h01, 2'h0, 3'b010);
    hit(8'h02, 2'h0, 3'b100);
    hit(8'h04, 2'h0, 3'b000);
    hit(8'h08, 2'h0, 3'b000);
    $display("test core sequence done");
    wr(REG_CH_CFG0 + 6'h8, cfg(PRE_NONE, ACT_SET));
    wr(REG_CH_CFG0 + 6'h9, cfg(4'h1, ACT_KEEP));
    hit(8'h00, 2'h2, 3'b000);
    hit(8'h01, 2'h1, 3'b011);
    hit(8'h00, 2'h2, 3'b100);
    $display("test system sequence done");
    u_core.branch(32'h11, 32'h22, 6'h33);
    rd(REG_BR_SRC, 32'h0);
    wr(REG_BR_CTRL, 32'h1);
    repeat (2) begin
      a = $urandom;
      last = $urandom;
      u_core.branch(a, last, a[5:0]);
      rd(REG_BR_SRC, a);
      rd(REG_BR_DST, last);
      rd(REG_BR_INFO, {26'h0, a[5:0]});
    end
    $display("test branch done");
    wr(REG_RANGE_START, 32'h140);
    wr(REG_RANGE_END, 32'h17f);
    rd(REG_RANGE_END, 32'h17f);
    for (int i = 0; i < 24; i++) begin
      c = 4'($urandom);
      a = (i < 4) ? corner[i] : 32'h120 + 32'($urandom % 128);
      w = 1'($urandom);
      id = ($urandom % 2 == 0) ? 8'h5a : 8'($urandom);
      wr(REG_RANGE_CTRL, {16'h0, 8'h5a, 4'h0, c});
      u_core.access(w, a, id);
      #1 check_bit("rangeHit", exp_hit(c, w, a, id), rangeHit);
      if (exp_hit(c, w, a, id) && c[3]) begin
        last = a;
        nCap++;
      end
    end
    rd(REG_STATUS, {16'h0, 4'(nCap > 8 ? 8 : nCap), 12'h0});
    if (nCap > 0) rd(REG_TRC_BASE + 6'((nCap - 1) % 8), last);
    $display("test range done");
    give_verdict();
  end
endmodule // sbt_trigger_tb
